// >>> logic/soe_flags_params.svh
`ifndef SOE_FLAGS_PARAMS_SVH
`define SOE_FLAGS_PARAMS_SVH
`define NUM_INPUTS 16
`define ACK_SEL_W 2
`define ACK_ON_OFF 2'h0
`define ACK_OFF_ON 2'h1
`define ACK_BOTH 2'h2
`define HOLD_DEFAULT 1'h0
`define FLAGS_RESET 16'h0000
`endif

// >>> logic/soe_flags_pkg.sv
package soe_flags_pkg;
  typedef logic [15:0] point_word_t;
  typedef logic [1:0] ack_sel_t;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/100ps
`include "soe_flags_params.svh"
module pin_sync
  import soe_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire point_word_t async_in,
  output point_word_t sync_out
);
  point_word_t meta_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= `FLAGS_RESET;
      sync_out <= `FLAGS_RESET;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// >>> logic/event_status_flags.sv
`timescale 1ns/100ps
`include "soe_flags_params.svh"
module event_status_flags
  import soe_flags_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // events from capture logic (same clock, except chatter_active, which is synchronised)
  input wire point_word_t chatter_active,
  input wire point_word_t filtered_in,
  input wire point_word_t rise_event,
  input wire point_word_t fall_event,
  input wire logic report_tick,
  input wire logic reset_all_events,
  // configuration
  input wire logic hold_first_stamp,
  // acknowledge from controller
  input wire logic ack_valid,
  input wire ack_sel_t edge_ack_select,
  input wire point_word_t fresh_stamp_ack,
  // status toward controller
  output point_word_t fault_flags,
  output point_word_t input_state,
  output point_word_t fresh_stamp_flags,
  output point_word_t stamp_overrun_flags,
  output point_word_t rise_stamp_write,
  output point_word_t fall_stamp_write,
  output logic report_send
);
  // synchronised chatter level, one bit per input
  point_word_t chatter_sync;
  // stamps waiting for an acknowledge, one word per edge direction
  point_word_t rise_held_r;
  point_word_t fall_held_r;
  // acknowledge decoded per edge direction
  logic ack_hits_rise;
  logic ack_hits_fall;
  point_word_t ack_rise;
  point_word_t ack_fall;
  point_word_t ack_fresh;
  // clear vectors: acknowledge or reset of all events
  point_word_t rise_clr;
  point_word_t fall_clr;
  point_word_t fresh_clr;
  // events that store a stamp this cycle
  point_word_t rise_take;
  point_word_t fall_take;
  point_word_t new_stamp;
  logic any_take;
  // new edge meets a pending stamp of the same direction
  point_word_t rise_collide;
  point_word_t fall_collide;
  point_word_t overrun_hit;

  // chatter comes from a slower detector domain
  // two flops: its level may change anywhere in our cycle
  pin_sync u_chatter_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in(chatter_active),
    .sync_out(chatter_sync)
  );

  // selector decode; code 3 matches neither edge
  function automatic logic sel_hits(input ack_sel_t sel, input logic rising);
    logic hit;
    hit = 1'b0;
    case (sel)
      `ACK_ON_OFF: begin
        hit = !rising;
      end
      `ACK_OFF_ON: begin
        hit = rising;
      end
      `ACK_BOTH: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    sel_hits = hit;
  endfunction

  // per-input acknowledge word, qualified by valid and by the edge match
  function automatic point_word_t ack_gate(input logic valid, input logic hit,
                                           input point_word_t ack_bits);
    if (valid && hit) begin
      ack_gate = ack_bits;
    end else begin
      ack_gate = `FLAGS_RESET;
    end
  endfunction

  // clear first, then set, so an event never loses to a same-cycle clear
  function automatic point_word_t set_over_clear(input point_word_t cur_flags,
                                                 input point_word_t clr_mask,
                                                 input point_word_t set_mask);
    set_over_clear = (cur_flags & ~clr_mask) | set_mask;
  endfunction

  // when holding, a pending same-edge stamp blocks the new one
  function automatic point_word_t stamp_allow(input point_word_t ev, input point_word_t held,
                                              input logic hold);
    if (hold) begin
      stamp_allow = ev & ~held;
    end else begin
      stamp_allow = ev;
    end
  endfunction

  // acks are one-cycle pulses; nothing here stretches them
  always_comb begin
    ack_hits_rise = sel_hits(edge_ack_select, 1'b1);
    ack_hits_fall = sel_hits(edge_ack_select, 1'b0);
    ack_rise = ack_gate(ack_valid, ack_hits_rise, fresh_stamp_ack);
    ack_fall = ack_gate(ack_valid, ack_hits_fall, fresh_stamp_ack);
    // the fresh flag ignores the selector, so code 3 still clears it
    ack_fresh = ack_gate(ack_valid, 1'b1, fresh_stamp_ack);
  end

  // reset of all events wipes pending stamps and fresh flags, never overrun
  always_comb begin
    rise_clr = reset_all_events ? ~`FLAGS_RESET : ack_rise;
    fall_clr = reset_all_events ? ~`FLAGS_RESET : ack_fall;
    fresh_clr = reset_all_events ? ~`FLAGS_RESET : ack_fresh;
  end

  // limitation: rise and fall on one input in one cycle both stamp
  always_comb begin
    rise_take = stamp_allow(rise_event, rise_held_r, hold_first_stamp);
    fall_take = stamp_allow(fall_event, fall_held_r, hold_first_stamp);
    new_stamp = rise_take | fall_take;
    any_take = |new_stamp;
  end

  // a collision overruns in both modes: skipped when holding, overwritten if not
  always_comb begin
    rise_collide = rise_event & rise_held_r;
    fall_collide = fall_event & fall_held_r;
    overrun_hit = rise_collide | fall_collide;
  end

  // fault follows chatter bit for bit, clears itself when it stops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_flags <= `FLAGS_RESET;
    end else begin
      fault_flags <= chatter_sync;
    end
  end

  // filtered level only; raw pin changes never reach the status word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      input_state <= `FLAGS_RESET;
    end else begin
      input_state <= filtered_in;
    end
  end

  // pending rise stamps; a matching selector or a reset of all events releases them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rise_held_r <= `FLAGS_RESET;
    end else begin
      rise_held_r <= set_over_clear(rise_held_r, rise_clr, rise_take);
    end
  end

  // pending fall stamps; a matching selector or a reset of all events releases them
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fall_held_r <= `FLAGS_RESET;
    end else begin
      fall_held_r <= set_over_clear(fall_held_r, fall_clr, fall_take);
    end
  end

  // fresh flag: a stored stamp of either edge sets it, ack or reset of all events clears it
  // an event in the clearing cycle must survive, or its stamp goes unseen
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fresh_stamp_flags <= `FLAGS_RESET;
    end else begin
      fresh_stamp_flags <= set_over_clear(fresh_stamp_flags, fresh_clr, new_stamp);
    end
  end

  // only a module reset clears overrun; acks and event resets do not
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stamp_overrun_flags <= `FLAGS_RESET;
    end else begin
      stamp_overrun_flags <= stamp_overrun_flags | overrun_hit;
    end
  end

  // store strobe for the rise stamp word; without holding it overwrites
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rise_stamp_write <= `FLAGS_RESET;
    end else begin
      rise_stamp_write <= rise_take;
    end
  end

  // store strobe for the fall stamp word; without holding it overwrites
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fall_stamp_write <= `FLAGS_RESET;
    end else begin
      fall_stamp_write <= fall_take;
    end
  end

  // one report after any stored stamp and at every interval tick
  // a skipped stamp sends nothing: the data has not changed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      report_send <= 1'b0;
    end else begin
      report_send <= report_tick || any_take;
    end
  end
endmodule

// >>> testbench/event_status_flags_assertions.sv
`timescale 1ns/100ps
module esf_chk
  import soe_flags_pkg::*;
(
  input wire logic clk_sys, sys_rst, hold_first_stamp, report_tick, report_send, ack_valid,
  input wire logic reset_all_events,
  input wire point_word_t chatter_active, filtered_in, rise_event, fall_event, fault_flags,
  input wire point_word_t input_state, fresh_stamp_flags, stamp_overrun_flags, rise_stamp_write
);
  // cycles since reset, so $past never reaches into reset
  logic [1:0] up_r;
  always_ff @(posedge clk_sys) up_r <= sys_rst ? 2'h0 : up_r + {1'h0, up_r != 2'h3};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_ev; |(rise_event | fall_event) && !hold_first_stamp; endsequence
  property p_flt; up_r == 2'h3 |-> fault_flags == $past(chatter_active, 3); endproperty
  property p_st; up_r != 2'h0 |-> input_state == $past(filtered_in); endproperty
  property p_tick; report_tick |=> report_send; endproperty
  property p_rep; s_ev |=> report_send; endproperty
  property p_rw; !hold_first_stamp |=> rise_stamp_write == $past(rise_event); endproperty
  property p_fr; s_ev |=> (fresh_stamp_flags & $past(rise_event | fall_event)) ==
    $past(rise_event | fall_event); endproperty
  property p_ovk; up_r != 2'h0 |-> (stamp_overrun_flags & $past(stamp_overrun_flags)) ==
    $past(stamp_overrun_flags); endproperty
  property p_clr; up_r != 2'h0 && !$past(ack_valid | reset_all_events) |->
    (~fresh_stamp_flags & $past(fresh_stamp_flags)) == 16'h0000; endproperty
  a_flt: assert property (p_flt) else $error("fault word lag wrong");
  a_st: assert property (p_st) else $error("input state wrong");
  a_tick: assert property (p_tick) else $error("no report on tick");
  a_rep: assert property (p_rep) else $error("no report on event");
  a_rw: assert property (p_rw) else $error("stamp not overwritten");
  a_fr: assert property (p_fr) else $error("fresh flag not set");
  a_ovk: assert property (p_ovk) else $error("overrun dropped");
  a_clr: assert property (p_clr) else $error("fresh cleared early");
endmodule

// >>> testbench/ctrl_model.sv
`timescale 1ns/100ps
module ctrl_model
  import soe_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic en,
  input wire logic link_lost,
  input wire point_word_t fresh_stamp_flags,
  input wire point_word_t fault_flags,
  output logic ack_valid,
  output ack_sel_t edge_ack_select,
  output point_word_t fresh_stamp_ack,
  output point_word_t fault_view
);
  initial {ack_valid, edge_ack_select, fresh_stamp_ack, fault_view} = '0;
  // dead link: controller shows every point faulted until it returns
  always @(posedge clk_sys) begin
    fault_view <= link_lost ? 16'hffff : fault_flags;
  end
  // selector 3 acks nothing pending: exercises that case too
  always @(posedge clk_sys) begin
    ack_valid <= en && |fresh_stamp_flags && !ack_valid;
    edge_ack_select <= 2'($urandom);
    fresh_stamp_ack <= fresh_stamp_flags ^ 16'($urandom & $urandom);
  end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb
  import soe_flags_pkg::*;
;
  logic clk_sys = 0, sys_rst = 1, report_tick = 0, reset_all_events = 0, hold_first_stamp = 0;
  logic en = 0, ack_valid, report_send, link_lost = 0, erep = 0;
  point_word_t chatter_active = 0, filtered_in = 0, rise_event = 0, fall_event = 0;
  point_word_t fresh_stamp_ack, fault_flags, input_state, fresh_stamp_flags;
  point_word_t stamp_overrun_flags, rise_stamp_write, fall_stamp_write;
  point_word_t ef, eo, ew, ewf, es, ev, pr, pf, sr, sf, fault_view;
  point_word_t cq[$] = '{16'h0000, 16'h0000, 16'h0000};
  ack_sel_t edge_ack_select;
  int n_errors = 0, check_count = 0;
  event_status_flags dut_u (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .chatter_active(chatter_active),
    .filtered_in(filtered_in),
    .rise_event(rise_event),
    .fall_event(fall_event),
    .report_tick(report_tick),
    .reset_all_events(reset_all_events),
    .hold_first_stamp(hold_first_stamp),
    .ack_valid(ack_valid),
    .edge_ack_select(edge_ack_select),
    .fresh_stamp_ack(fresh_stamp_ack),
    .fault_flags(fault_flags),
    .input_state(input_state),
    .fresh_stamp_flags(fresh_stamp_flags),
    .stamp_overrun_flags(stamp_overrun_flags),
    .rise_stamp_write(rise_stamp_write),
    .fall_stamp_write(fall_stamp_write),
    .report_send(report_send)
  );
  ctrl_model ctl_u (
    .clk_sys(clk_sys),
    .en(en),
    .link_lost(link_lost),
    .fresh_stamp_flags(fresh_stamp_flags),
    .fault_flags(fault_flags),
    .ack_valid(ack_valid),
    .edge_ack_select(edge_ack_select),
    .fresh_stamp_ack(fresh_stamp_ack),
    .fault_view(fault_view)
  );
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input point_word_t g, input point_word_t e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (!sys_rst) begin
      chk(fresh_stamp_flags, ef);
      chk(stamp_overrun_flags, eo);
      chk(rise_stamp_write, ew);
      chk(fall_stamp_write, ewf);
      chk(fault_flags, cq[0]);
      chk(fault_view, ev);
      chk(input_state, es);
      chk_bit(report_send, erep);
    end
    sr = rise_event & ~(pr & {16{hold_first_stamp}});
    sf = fall_event & ~(pf & {16{hold_first_stamp}});
    eo |= (rise_event & pr) | (fall_event & pf);
    ew = sr;
    ewf = sf;
    erep = report_tick || (|sr) || (|sf);
    es = filtered_in;
    ev = link_lost ? 16'hffff : cq[0];
    cq.push_back(chatter_active);
    void'(cq.pop_front());
    if (ack_valid) begin
      ef &= ~fresh_stamp_ack;
      if (edge_ack_select == 2'h0 || edge_ack_select == 2'h2) pf &= ~fresh_stamp_ack;
      if (edge_ack_select == 2'h1 || edge_ack_select == 2'h2) pr &= ~fresh_stamp_ack;
    end
    if (reset_all_events) {ef, pr, pf} = '0;
    ef |= sr | sf;
    pr |= sr;
    pf |= sf;
    if (sys_rst) {ef, eo, ew, ewf, pr, pf} = '0;
  end
  initial begin
    void'($urandom(32'hbf3f));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      rise_event <= 16'($urandom & $urandom & $urandom);
      fall_event <= 16'($urandom & $urandom & $urandom);
      chatter_active <= 16'($urandom);
      filtered_in <= 16'($urandom);
      hold_first_stamp <= i[9];
      en <= i[5];
      link_lost <= i[8:6] == 3'h5;
      report_tick <= i[4:0] == 5'h00;
      reset_all_events <= $urandom_range(63) == 0;
    end
    results;
  end
  initial begin
    #40000;
    n_errors++;
    results;
  end
endmodule
bind event_status_flags esf_chk chk_u (
  .clk_sys(clk_sys),
  .sys_rst(sys_rst),
  .hold_first_stamp(hold_first_stamp),
  .report_tick(report_tick),
  .report_send(report_send),
  .ack_valid(ack_valid),
  .reset_all_events(reset_all_events),
  .chatter_active(chatter_active),
  .filtered_in(filtered_in),
  .rise_event(rise_event),
  .fall_event(fall_event),
  .fault_flags(fault_flags),
  .input_state(input_state),
  .fresh_stamp_flags(fresh_stamp_flags),
  .stamp_overrun_flags(stamp_overrun_flags),
  .rise_stamp_write(rise_stamp_write)
);
